/* an_regs_pkg.sv */
// Package of register indices, field positions and reset values for the
// auto-negotiation expansion and next-page transmit registers.
// Assumes a serial management front end that decodes register reads and writes.
//
// Summary of operation
// - Latch parallel-detection fault until register read
// - Report partner next-page ability from received word
// - Always report local next-page ability as one
// - Latch page-received when new partner word stored
// - Reading expansion register clears page-received
// - Partner autoneg-able set after valid pulse bursts
// - Outgoing more-pages bit follows transmit field
// - Next pages sent only if partner supports
// - Reserved transmit bit reads as zero
// - Message-page field drives outgoing message-page bit
// - Comply field drives outgoing second acknowledge bit
// - Toggle inverts per transmitted next-page word
// - First toggle is inverse of base bit 11
// - Eleven-bit code field fills outgoing code bits
// - Expansion reserved upper bits read zero
package an_regs_pkg;
    localparam logic [4:0] EXPANSION_ADDR = 5'h06;
    localparam logic [4:0] NP_TX_ADDR = 5'h07;
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic [15:0] NP_TX_WRITE_MASK = 16'hB7FF;
    localparam int MORE_PAGES_POS = 15;
    localparam int TOGGLE_POS = 11;
    localparam int PAR_FAULT_POS = 4;
    localparam int LP_NP_ABLE_POS = 3;
    localparam int NP_ABLE_POS = 2;
    localparam int PAGE_RX_POS = 1;
    localparam int LP_AN_ABLE_POS = 0;
    localparam logic LOCAL_NP_ABLE = 1'b1;
endpackage

/* latch_high_flag.sv */
// Holds one latch-high status flag.
// Assumes the read strobe and the event both come from the management clock domain.
`timescale 1ns/1ps
module latch_high_flag (
    input wire logic mclk_in, // Management clock.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire logic event_in, // Current condition or event.
    input wire logic read_in, // Owning register is being read.
    output logic flag_out // Latched value.
);
    logic flag_q;
    logic flag_d;
    // A set in the read cycle wins, so no event is lost.
    assign flag_d = event_in | (flag_q & ~read_in);
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag_out = flag_q;
endmodule

/* autoneg_expansion_next_page_regs.sv */
// Expansion status register and next-page transmit register with the
// outgoing next-page code word.
// Assumes the arbitration engine supplies single-cycle event pulses.
`timescale 1ns/1ps
module autoneg_expansion_next_page_regs
    import an_regs_pkg::*;
(
    input wire logic mclk_in, // Management clock, 40 MHz.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire logic [4:0] reg_addr_in, // Register address.
    input wire logic reg_rd_in, // Read strobe, one cycle.
    input wire logic reg_wr_in, // Write strobe, one cycle.
    input wire logic [15:0] reg_wdata_in, // Write data.
    input wire logic par_fault_in, // Parallel detection fault seen.
    input wire logic page_stored_in, // Partner word stored, pulse.
    input wire logic partner_np_in, // Partner word has more-pages set.
    input wire logic flp_valid_in, // Valid pulse bursts from partner.
    input wire logic base_bit11_in, // Bit 11 of sent base word.
    input wire logic base_sent_in, // Base word sent, pulse.
    input wire logic np_sent_in, // Next-page word sent, pulse.
    output logic [15:0] reg_rdata_out, // Read data, valid after read.
    output logic [15:0] np_word_out, // Outgoing next-page code word.
    output logic np_enable_out // Next-page transmission enabled.
);
    logic [15:0] np_tx_q;
    logic toggle_q;
    logic lp_np_q;
    logic lp_an_q;
    logic [15:0] rdata_q;
    logic [15:0] word_q;
    logic en_q;
    logic fault_flag;
    logic page_flag;
    wire exp_read = reg_rd_in && (reg_addr_in == EXPANSION_ADDR);
    wire tx_write = reg_wr_in && (reg_addr_in == NP_TX_ADDR);
    wire [15:0] tx_write_val = (reg_wdata_in & NP_TX_WRITE_MASK);
    wire [15:0] exp_val = {11'h000, fault_flag, lp_np_q, LOCAL_NP_ABLE,
        page_flag, lp_an_q};
    wire [15:0] tx_val = (np_tx_q & NP_TX_WRITE_MASK) | (16'(toggle_q) << TOGGLE_POS);

    latch_high_flag u_fault (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .event_in(par_fault_in),
        .read_in(exp_read),
        .flag_out(fault_flag)
    );

    latch_high_flag u_page (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .event_in(page_stored_in),
        .read_in(exp_read),
        .flag_out(page_flag)
    );

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            np_tx_q <= NP_TX_RESET;
        end else if (tx_write) begin
            np_tx_q <= tx_write_val;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            toggle_q <= 1'b0;
        end else if (base_sent_in) begin
            toggle_q <= ~base_bit11_in;
        end else if (np_sent_in) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Partner status tracks the receive side; autoneg-able clears only at reset, next-page ability follows each stored page.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            lp_np_q <= 1'b0;
            lp_an_q <= 1'b0;
        end else begin
            if (page_stored_in) begin
                lp_np_q <= partner_np_in;
            end
            if (flp_valid_in) begin
                lp_an_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rdata_q <= 16'h0000;
            word_q <= 16'h0000;
            en_q <= 1'b0;
        end else begin
            if (reg_rd_in) begin
                rdata_q <= (reg_addr_in == EXPANSION_ADDR) ? exp_val :
                    (reg_addr_in == NP_TX_ADDR) ? tx_val : 16'h0000;
            end
            // More-pages, message-page, comply and code fields pass straight through.
            word_q <= tx_val;
            en_q <= np_tx_q[MORE_PAGES_POS] & lp_np_q;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign np_word_out = word_q;
    assign np_enable_out = en_q;
endmodule

/* lp_model.sv */
// Remote partner model: stores one page per request.
// Assumes requests change just after a rising edge.
`timescale 1ns/1ps
module lp_model (
    input wire logic mclk_in, // Clock.
    input wire logic go_in, // Page request.
    input wire logic np_in, // More-pages bit.
    output logic page_out = 1'b0, // Page stored.
    output logic np_out = 1'b0 // Page more-pages.
);
    // Between pages the bit wanders, so a stale value is never trusted.
    always_ff @(posedge mclk_in) begin
        page_out <= go_in;
        np_out <= go_in ? np_in : ~np_out;
    end
endmodule

/* an_regs_monitor.sv */
// Assertions on the register block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module an_regs_monitor (
    input wire logic mclk_in, srst_in, reg_rd_in, par_fault_in, page_stored_in, // In.
    input wire logic flp_valid_in, base_bit11_in, base_sent_in, np_sent_in, // In.
    input wire logic [4:0] reg_addr_in, // In.
    input wire logic [15:0] reg_rdata_out, np_word_out, // Out.
    input wire logic np_enable_out // Out.
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    wire logic r = reg_rd_in && reg_addr_in == 5'h06;
    wire logic t = base_sent_in || np_sent_in;
    wire logic [15:0] q = reg_rdata_out;
    wire logic [15:0] w = np_word_out;
    a_fixed_bits: assert property (r |=> q[15:5] == 11'h000 && q[2])
        else $error("fixed bits wrong");
    a_fault_held: assert property (par_fault_in ##1 r |=> q[4])
        else $error("fault flag lost");
    a_page_held: assert property (page_stored_in ##1 r |=> q[1])
        else $error("page flag lost");
    a_page_clear: assert property (r && !page_stored_in ##1 r && !page_stored_in |=> !q[1])
        else $error("page flag kept");
    a_partner_able: assert property (flp_valid_in ##1 r |=> q[0])
        else $error("able flag lost");
    a_enable_gate: assert property (np_enable_out |-> w[15] && !w[14])
        else $error("bad enable");
    a_toggle_step: assert property (np_sent_in && !base_sent_in ##1 !t |=> w[11] != $past(w[11]))
        else $error("toggle stuck");
    a_toggle_seed: assert property (base_sent_in ##1 !t |=> w[11] == !$past(base_bit11_in, 2))
        else $error("toggle seed wrong");
    cover property (page_stored_in ##1 r);
    cover property (np_sent_in);
    cover property (np_enable_out);
endmodule
bind autoneg_expansion_next_page_regs an_regs_monitor u_an_regs_monitor (.*);

/* autoneg_expansion_next_page_regs_tb.sv */
// Self-checking bench for the register block.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module autoneg_expansion_next_page_regs_tb
    import an_regs_pkg::*;
;
    logic clk = 0, rst = 1, rd = 0, wr = 0, pf = 0, fv = 0, b11 = 0, bs = 0, ns = 0;
    logic go = 0, gnp = 0, tg = 0, en, ps, pnp;
    logic [4:0] adr = 0;
    logic [15:0] wd = 0, rdat, word, d;
    int err_count = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    lp_model u_lp_model (.mclk_in(clk), .go_in(go), .np_in(gnp), .page_out(ps), .np_out(pnp));
    autoneg_expansion_next_page_regs u_autoneg_expansion_next_page_regs (.mclk_in(clk),
        .srst_in(rst), .reg_addr_in(adr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wd),
        .par_fault_in(pf), .page_stored_in(ps), .partner_np_in(pnp), .flp_valid_in(fv),
        .base_bit11_in(b11), .base_sent_in(bs), .np_sent_in(ns), .reg_rdata_out(rdat),
        .np_word_out(word), .np_enable_out(en));
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // The second cycle lets a written value reach the outgoing word.
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
        adr = a; wd = v; wr = w; rd = !w;
        step();
        wr = 0; rd = 0;
        if (!w) `CHK(rdat, v)
        step();
    endtask
    function automatic logic [15:0] f7(input logic [15:0] v);
        return {v[15], 1'b0, v[13:12], tg, v[10:0]};
    endfunction
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        step(4000);
        err_count++;
        final_report();
    end
    initial begin
        void'($urandom(32'hA12C));
        step(12);
        rst = 0;
        step();
        `CHK(word, NP_TX_RESET)
        acc(0, NP_TX_ADDR, NP_TX_RESET);
        acc(0, EXPANSION_ADDR, 16'h0004);
        acc(0, 5'h1F, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            d = i < 2 ? {16{i[0]}} : 16'($urandom);
            d[14] = 1'b0;
            acc(1, NP_TX_ADDR, d);
            `CHK(word, f7(d))
            `CHK(en, 1'b0)
            acc(0, NP_TX_ADDR, f7(d));
        end
        $display("write test done");
        pf = 1; fv = 1; go = 1; gnp = 1;
        step();
        go = 0;
        step();
        pf = 0; adr = EXPANSION_ADDR; rd = 1;
        step();
        `CHK(rdat, 16'h001F)
        step();
        rd = 0;
        `CHK(rdat, 16'h000D)
        acc(1, NP_TX_ADDR, 16'h8000);
        `CHK(en, 1'b1)
        $display("latch test done");
        b11 = 1'($urandom);
        bs = 1;
        step();
        bs = 0; tg = !b11;
        step();
        `CHK(word[11], tg)
        for (int i = 0; i < 3; i++) begin
            ns = 1;
            step();
            ns = 0; tg = !tg;
            step();
            `CHK(word[11], tg)
        end
        gnp = 0; go = 1;
        step();
        go = 0;
        step(2);
        `CHK(en, 1'b0)
        acc(0, EXPANSION_ADDR, 16'h0007);
        $display("toggle test done");
        final_report();
    end
endmodule
